// file: common/mpp_pkg.sv
/*
 Package for the pin port mux: register offsets, field positions,
 reset values and widths. Assumes an APB slave with 32-bit data.
*/
`default_nettype none
package mpp_pkg;
    localparam logic [7:0] MPP_OFS_DPORT = 8'h00;
    localparam logic [7:0] MPP_OFS_P0 = 8'h04;
    localparam logic [7:0] MPP_OFS_P1 = 8'h08;
    localparam logic [7:0] MPP_OFS_P2 = 8'h0C;
    localparam logic [7:0] MPP_OFS_P3 = 8'h10;
    localparam logic [7:0] MPP_OFS_PULLUP = 8'h14;
    localparam logic [7:0] MPP_OFS_KEYON = 8'h18;
    localparam logic [7:0] MPP_OFS_FUNC = 8'h1C;
    localparam logic [7:0] MPP_OFS_IRQCTL = 8'h20;
    localparam logic [7:0] MPP_OFS_SKIP = 8'h24;
    localparam logic [7:0] MPP_OFS_STATUS = 8'h28;
    localparam logic [7:0] MPP_OFS_MASK = 8'h2C;
    // Pin vector widths
    localparam int MPP_D_W = 6;
    localparam int MPP_WIDE_W = 4;
    localparam int MPP_NARROW_W = 2;
    // Pull-up / key-on layout: [3:0] p0, [7:4] p1, [9:8] p2, [11:10] d2,d3
    localparam int MPP_KEY_W = 12;
    // Function select fields
    localparam int MPP_FN_TMR_OUT = 0;
    localparam int MPP_FN_TMR_SEL = 1;
    localparam int MPP_FN_ANALOG = 2;
    // Interrupt control: pin input enable bit
    localparam int MPP_IRQ_PIN_EN = 3;
    // Status bits
    localparam int MPP_ST_EXTIRQ = 0;
    localparam int MPP_ST_WAKE = 1;
    localparam int MPP_ST_W = 2;
    // Reset values: latches released (input ready)
    localparam logic [5:0] MPP_RST_D = 6'h3F;
    localparam logic [3:0] MPP_RST_WIDE = 4'hF;
    localparam logic [1:0] MPP_RST_NARROW = 2'h3;
endpackage : mpp_pkg
`default_nettype wire

// file: verif/mpp_board_model.sv
/*
 Board model for the pin port: open-drain lines, keys that pull low.
 Assumes a low output enable from the port means that line is pulled low.
*/
`timescale 1ns/100ps
`default_nettype none
module mpp_board_model (
    input wire logic [17:0] oe_n,
    input wire logic [17:0] key_low,
    output logic [17:0] pins
);
    // ************************************
    // Wired-and of port and keys
    // ************************************
    // open-drain wired-and
    // Board resistors hold released lines high, so no line ever floats
    assign pins = oe_n & ~key_low;
endmodule : mpp_board_model
`default_nettype wire

// file: verif/mpp_pin_port_tb_top.sv
/*
 Testbench for the pin port: APB tasks and directed checks.
 Assumes the board model and one-wait-state APB answers.
*/
`timescale 1ns/100ps
`default_nettype none
module mpp_pin_port_tb_top;
    import mpp_pkg::*;
    // ************************************
    // Signals and instances
    // ************************************
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, err, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] six_bit_port_in, six_bit_port_oe_n;
    logic [3:0] wide_port_zero_in, wide_port_zero_oe_n, analog_select;
    logic [3:0] wide_port_one_in, wide_port_one_oe_n;
    logic [1:0] narrow_port_two_in, narrow_port_two_oe_n;
    logic [1:0] narrow_port_three_in, narrow_port_three_oe_n;
    logic [11:0] pullup_en;
    logic [17:0] oe_n, key_low, pins;
    logic timer1_underflow, timer2_underflow, timer2_event_clk, b;
    logic external_irq_req, ram_backup, wakeup_req, reset_pin_oe_n;
    logic wdt_reset, por_reset, vdrop_reset, rpin_out;
    logic [5:0] d_out;
    logic [3:0] w0_out, w1_out;
    logic [1:0] n2_out, n3_out;
    logic [18:0] outs;
    int miscompares, checked, cycles, irq_n, wake_n, i;
    mpp_pin_port i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .six_bit_port_in,
        .six_bit_port_out(d_out), .six_bit_port_oe_n, .wide_port_zero_in,
        .wide_port_zero_out(w0_out), .wide_port_zero_oe_n, .wide_port_one_in,
        .wide_port_one_out(w1_out), .wide_port_one_oe_n,
        .narrow_port_two_in, .narrow_port_two_out(n2_out),
        .narrow_port_two_oe_n, .narrow_port_three_in,
        .narrow_port_three_out(n3_out), .narrow_port_three_oe_n, .pullup_en,
        .analog_select, .timer1_underflow, .timer2_underflow,
        .timer2_event_clk, .external_irq_req, .ram_backup, .wakeup_req,
        .wdt_reset, .por_reset, .vdrop_reset, .reset_pin_out(rpin_out),
        .reset_pin_oe_n, .irq);
    assign oe_n = {six_bit_port_oe_n, wide_port_zero_oe_n,
        wide_port_one_oe_n, narrow_port_two_oe_n, narrow_port_three_oe_n};
    // Open-drain data outputs never drive high
    assign outs = {d_out, w0_out, w1_out, n2_out, n3_out, rpin_out};
    mpp_board_model i_board (.oe_n(oe_n), .key_low(key_low), .pins(pins));
    assign {six_bit_port_in, wide_port_zero_in, wide_port_one_in,
        narrow_port_two_in, narrow_port_three_in} = pins;
    // ************************************
    // Tasks
    // ************************************
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
            input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // ************************************
    // Clock, monitors and tests
    // ************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Pulses are one cycle, so count them at every edge
    always @(posedge ref_clk) begin
        irq_n += (external_irq_req === 1'b1);
        wake_n += (wakeup_req === 1'b1);
        cycles++;
        if (cycles >= 4000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {timer1_underflow, timer2_underflow, ram_backup} = 3'h0;
        {wdt_reset, por_reset, vdrop_reset, key_low} = 21'h0;
        tick(3);
        rst <= 1'b0;
        tick(1);
        chk("oe_n", 32'h3FFFF, 32'(oe_n));
        chk("outs", 32'h0, 32'(outs));
        rdchk(MPP_OFS_DPORT, 32'h3F, "dport");
        wr(MPP_OFS_DPORT, 32'h15);
        tick(1);
        chk("d_oe_n", 32'h15, 32'(six_bit_port_oe_n));
        for (i = 0; i < 6; i++) begin
            wr(MPP_OFS_SKIP, 32'(i));
            rdchk(MPP_OFS_SKIP, 32'((6'h15 >> i) & 6'h1), "skip");
        end
        wr(MPP_OFS_DPORT, 32'h3F);
        for (i = 0; i < 4; i++) wr(MPP_OFS_P0 + 8'(4 * i), 32'hFFFFFFF6);
        tick(1);
        chk("port_oe_n", 32'h66A, 32'(oe_n[11:0]));
        for (i = 0; i < 4; i++) begin
            rdchk(MPP_OFS_P0 + 8'(4 * i), (i < 2) ? 32'h6 : 32'h2, "p");
            wr(MPP_OFS_P0 + 8'(4 * i), 32'hF);
        end
        wr(MPP_OFS_PULLUP, 32'hFFF);
        tick(1);
        chk("pullup", 32'hFFF, 32'(pullup_en));
        wr(MPP_OFS_FUNC, 32'h4);
        wr(MPP_OFS_P3, 32'h1);
        tick(1);
        chk("analog", 32'hF, 32'(analog_select));
        chk("p3_oe_n", 32'h1, 32'(narrow_port_three_oe_n));
        wr(MPP_OFS_P3, 32'h3);
        wr(MPP_OFS_FUNC, 32'h1);
        tick(1);
        b = wide_port_one_oe_n[2];
        for (i = 0; i < 2; i++) begin
            {timer1_underflow, timer2_underflow} <= 2'h3;
            tick(1);
            {timer1_underflow, timer2_underflow} <= 2'h0;
            tick(2);
            b = ~b;
            chk("div", 32'(b), 32'(wide_port_one_oe_n[2]));
        end
        key_low[6] <= 1'b1;
        rdchk(MPP_OFS_P1, 32'hB, "p1_in");
        chk("evclk", 32'h0, 32'(timer2_event_clk));
        wr(MPP_OFS_FUNC, 32'h0);
        key_low[6] <= 1'b0;
        tick(3);
        chk("evclk", 32'h1, 32'(timer2_event_clk));
        wr(MPP_OFS_MASK, 32'h3);
        for (i = 0; i < 2; i++) begin
            key_low[7] <= 1'b1;
            tick(2);
            key_low[7] <= 1'b0;
            tick(3);
            chk("irq_req", 32'(i), 32'(irq_n));
            rdchk(MPP_OFS_STATUS, 32'(i), "status");
            chk("irq", 32'(i), 32'(irq));
            wr(MPP_OFS_IRQCTL, 32'h8);
        end
        rdchk(MPP_OFS_P1, 32'hF, "p1_irq");
        wr(MPP_OFS_MASK, 32'h2);
        tick(2);
        chk("irq_mask", 32'h0, 32'(irq));
        wr(MPP_OFS_STATUS, 32'h1);
        rdchk(MPP_OFS_STATUS, 32'h0, "w1c");
        wr(MPP_OFS_PULLUP, 32'h1);
        wr(MPP_OFS_KEYON, 32'h1);
        ram_backup <= 1'b1;
        key_low <= 18'h201;
        tick(3);
        chk("no_wake", 32'h0, 32'(wake_n));
        key_low[8] <= 1'b1;
        tick(3);
        chk("wake", 32'h1, 32'(wake_n));
        rdchk(MPP_OFS_STATUS, 32'h2, "st_wake");
        chk("irq_wake", 32'h1, 32'(irq));
        wr(MPP_OFS_PULLUP, 32'h401);
        wr(MPP_OFS_KEYON, 32'h401);
        key_low[14] <= 1'b1;
        tick(3);
        chk("wake_alias", 32'h2, 32'(wake_n));
        wr(MPP_OFS_STATUS, 32'h2);
        {ram_backup, key_low} <= 19'h0;
        for (i = 0; i < 3; i++) begin
            {wdt_reset, por_reset, vdrop_reset} <= 3'h4 >> i;
            tick(2);
            chk("rpin_lo", 32'h0, 32'(reset_pin_oe_n));
            {wdt_reset, por_reset, vdrop_reset} <= 3'h0;
            tick(2);
            chk("rpin_hi", 32'h1, 32'(reset_pin_oe_n));
        end
        chk("outs_end", 32'h0, 32'(outs));
        wr(8'h02, 32'h0);
        chk("err_w", 32'h1, 32'(err));
        rdchk(8'h30, 32'h0, "unmapped");
        chk("err_r", 32'h1, 32'(err));
        print_verdict();
    end
endmodule : mpp_pin_port_tb_top
`default_nettype wire

// file: verilog/mpp_pin_port.sv
/*
 Pin port mux with APB register access, open-drain pins, pull-up and
 key-on wakeup enables, shared timer/irq/analog pins and reset pin.
 Assumes pin inputs are already synchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module mpp_pin_port
    import mpp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] six_bit_port_in,
    output logic [5:0] six_bit_port_out,
    output logic [5:0] six_bit_port_oe_n,
    input wire logic [3:0] wide_port_zero_in,
    output logic [3:0] wide_port_zero_out,
    output logic [3:0] wide_port_zero_oe_n,
    input wire logic [3:0] wide_port_one_in,
    output logic [3:0] wide_port_one_out,
    output logic [3:0] wide_port_one_oe_n,
    input wire logic [1:0] narrow_port_two_in,
    output logic [1:0] narrow_port_two_out,
    output logic [1:0] narrow_port_two_oe_n,
    input wire logic [1:0] narrow_port_three_in,
    output logic [1:0] narrow_port_three_out,
    output logic [1:0] narrow_port_three_oe_n,
    output logic [11:0] pullup_en,
    output logic [3:0] analog_select,
    input wire logic timer1_underflow,
    input wire logic timer2_underflow,
    output logic timer2_event_clk,
    output logic external_irq_req,
    input wire logic ram_backup,
    output logic wakeup_req,
    input wire logic wdt_reset,
    input wire logic por_reset,
    input wire logic vdrop_reset,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    output logic irq
);
    // ************************************************
    // Registers
    // ************************************************
    logic [5:0] d_latch_reg;
    logic [3:0] p0_latch_reg;
    logic [3:0] p1_latch_reg;
    logic [1:0] p2_latch_reg;
    logic [1:0] p3_latch_reg;
    logic [11:0] pullup_reg;
    logic [11:0] keyon_reg;
    logic [2:0] func_reg;
    logic [3:0] irqctl_reg;
    logic [2:0] skip_sel_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic tmr_div_reg;
    logic irq_pin_dly_reg;
    logic [11:0] key_lvl;
    logic [11:0] key_dly_reg;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic skip_bit;
    logic tmr_src;
    logic [1:0] st_set;

    // Write only once per transfer, so a w1c never clears twice
    assign wr_en = psel && penable && pwrite && !pready;
    assign rd_en = psel && penable && !pwrite;
    assign addr_ok = (paddr <= MPP_OFS_MASK) && (paddr[1:0] == 2'h0);
    // Skip test level; indexes six and seven read zero
    assign skip_bit = (skip_sel_reg < 3'h6) && six_bit_port_in[skip_sel_reg];
    assign tmr_src = func_reg[MPP_FN_TMR_SEL] ? timer2_underflow
                                              : timer1_underflow;
    // Six-bit bits two/three double as alias pins
    assign key_lvl = {six_bit_port_in[3:2], narrow_port_two_in,
                      wide_port_one_in, wide_port_zero_in};

    // ************************************************
    // Port latches
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            d_latch_reg <= MPP_RST_D;
            p0_latch_reg <= MPP_RST_WIDE;
            p1_latch_reg <= MPP_RST_WIDE;
            p2_latch_reg <= MPP_RST_NARROW;
            p3_latch_reg <= MPP_RST_NARROW;
        end else if (wr_en) begin
            case (paddr)
                MPP_OFS_DPORT: d_latch_reg <= pwdata[5:0];
                MPP_OFS_P0: p0_latch_reg <= pwdata[3:0];
                MPP_OFS_P1: p1_latch_reg <= pwdata[3:0];
                MPP_OFS_P2: p2_latch_reg <= pwdata[1:0];
                MPP_OFS_P3: p3_latch_reg <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ************************************************
    // Control registers
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pullup_reg <= 12'h000;
            keyon_reg <= 12'h000;
            func_reg <= 3'h0;
            irqctl_reg <= 4'h0;
            skip_sel_reg <= 3'h0;
            mask_reg <= 2'h0;
        end else if (wr_en) begin
            case (paddr)
                MPP_OFS_PULLUP: pullup_reg <= pwdata[11:0];
                MPP_OFS_KEYON: keyon_reg <= pwdata[11:0];
                MPP_OFS_FUNC: func_reg <= pwdata[2:0];
                MPP_OFS_IRQCTL: irqctl_reg <= pwdata[3:0];
                MPP_OFS_SKIP: skip_sel_reg <= pwdata[2:0];
                MPP_OFS_MASK: mask_reg <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ************************************************
    // Pin drivers
    // ************************************************
    // Pins: out is always low, oe_n low only while pulling down
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            six_bit_port_out <= 6'h00;
            six_bit_port_oe_n <= 6'h3F;
            wide_port_zero_out <= 4'h0;
            wide_port_zero_oe_n <= 4'hF;
            wide_port_one_out <= 4'h0;
            wide_port_one_oe_n <= 4'hF;
            narrow_port_two_out <= 2'h0;
            narrow_port_two_oe_n <= 2'h3;
            narrow_port_three_out <= 2'h0;
            narrow_port_three_oe_n <= 2'h3;
            pullup_en <= 12'h000;
            analog_select <= 4'h0;
        end else begin
            six_bit_port_oe_n <= d_latch_reg;
            wide_port_zero_oe_n <= p0_latch_reg;
            // Wide one bit two carries the timer pin
            // Timer output overrides latch on bit two
            wide_port_one_oe_n <= {p1_latch_reg[3],
                func_reg[MPP_FN_TMR_OUT] ? tmr_div_reg : p1_latch_reg[2],
                p1_latch_reg[1:0]};
            // Analog select leaves port drive intact
            narrow_port_two_oe_n <= p2_latch_reg;
            narrow_port_three_oe_n <= p3_latch_reg;
            // Narrow three has no pull-up bits
            pullup_en <= pullup_reg;
            analog_select <= {4{func_reg[MPP_FN_ANALOG]}};
        end
    end

    // ************************************************
    // Timer pin and external irq
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tmr_div_reg <= 1'b0;
            timer2_event_clk <= 1'b0;
            external_irq_req <= 1'b0;
            irq_pin_dly_reg <= 1'b1;
        end else begin
            if (tmr_src) begin
                tmr_div_reg <= !tmr_div_reg;
            end
            timer2_event_clk <= wide_port_one_in[2];
            // Edge tracks raw pin: enabling raises no false request
            irq_pin_dly_reg <= wide_port_one_in[3];
            external_irq_req <= wide_port_one_in[3] &&
                irqctl_reg[MPP_IRQ_PIN_EN] && !irq_pin_dly_reg;
        end
    end

    // ************************************************
    // Key-on wakeup
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            key_dly_reg <= 12'hFFF;
            wakeup_req <= 1'b0;
        end else begin
            key_dly_reg <= key_lvl;
            wakeup_req <= ram_backup &&
                          |(keyon_reg & key_dly_reg & ~key_lvl);
        end
    end

    // ************************************************
    // Reset pin
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reset_pin_out <= 1'b0;
            reset_pin_oe_n <= 1'b1;
        end else begin
            reset_pin_out <= 1'b0;
            reset_pin_oe_n <= !(wdt_reset || por_reset || vdrop_reset);
        end
    end

    // ************************************************
    // Interrupt status
    // ************************************************
    assign st_set = {wakeup_req, external_irq_req};
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_reg <= 2'h0;
            irq <= 1'b0;
        end else begin
            // Set wins over write-one clear
            if (wr_en && paddr == MPP_OFS_STATUS) begin
                status_reg <= (status_reg & ~pwdata[1:0]) | st_set;
            end else begin
                status_reg <= status_reg | st_set;
            end
            irq <= |(status_reg & mask_reg);
        end
    end

    // ************************************************
    // APB read and answer
    // ************************************************
    // Answer lands one cycle after penable rises
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            prdata <= 32'h00000000;
            if (rd_en && !pready) begin
                case (paddr)
                    MPP_OFS_DPORT: prdata <= {26'h0, six_bit_port_in};
                    MPP_OFS_P0: prdata <= {28'h0, wide_port_zero_in};
                    MPP_OFS_P1: prdata <= {28'h0, wide_port_one_in};
                    MPP_OFS_P2: prdata <= {30'h0, narrow_port_two_in};
                    MPP_OFS_P3: prdata <= {30'h0, narrow_port_three_in};
                    MPP_OFS_PULLUP: prdata <= {20'h0, pullup_reg};
                    MPP_OFS_KEYON: prdata <= {20'h0, keyon_reg};
                    MPP_OFS_FUNC: prdata <= {29'h0, func_reg};
                    MPP_OFS_IRQCTL: prdata <= {28'h0, irqctl_reg};
                    MPP_OFS_SKIP: prdata <= {31'h0, skip_bit};
                    MPP_OFS_STATUS: prdata <= {30'h0, status_reg};
                    MPP_OFS_MASK: prdata <= {30'h0, mask_reg};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_open_drain_d: assert property (
        !rst |=> six_bit_port_oe_n == $past(d_latch_reg))
        else $error("six-bit pin drive differs from latch");
    a_reset_pin_low: assert property (
        (wdt_reset || por_reset || vdrop_reset) |=> !reset_pin_oe_n)
        else $error("reset pin not pulled low");
    a_irq_blocked: assert property (
        !irqctl_reg[MPP_IRQ_PIN_EN] |=> !external_irq_req)
        else $error("irq pin passed while disabled");
    a_wake_only_backup: assert property (
        !ram_backup |=> !wakeup_req)
        else $error("wakeup outside back-up");
    a_tmr_toggle: assert property (
        tmr_src |=> tmr_div_reg != $past(tmr_div_reg))
        else $error("timer divider did not toggle");
    a_narrow3_drive: assert property (
        !rst |=> narrow_port_three_oe_n == $past(p3_latch_reg))
        else $error("narrow three drive wrong");
    a_pullup_copy: assert property (
        !rst |=> pullup_en == $past(pullup_reg))
        else $error("pull-up output wrong");
    a_event_clk: assert property (
        !rst |=> timer2_event_clk == $past(wide_port_one_in[2]))
        else $error("event clock not following pin");
    a_status_sticky: assert property (
        external_irq_req |=> status_reg[MPP_ST_EXTIRQ])
        else $error("irq status lost");
    a_wide0_drive: assert property (
        !rst |=> wide_port_zero_oe_n == $past(p0_latch_reg))
        else $error("wide zero drive differs from latch");
    a_narrow2_drive: assert property (
        !rst |=> narrow_port_two_oe_n == $past(p2_latch_reg))
        else $error("narrow two drive differs from latch");
    a_analog_sel: assert property (
        !rst |=> analog_select == {4{$past(func_reg[MPP_FN_ANALOG])}})
        else $error("analog select wrong");
    a_tmr_pin_out: assert property (
        func_reg[MPP_FN_TMR_OUT] |=>
            wide_port_one_oe_n[2] == $past(tmr_div_reg))
        else $error("timer output not on pin");
    a_irq_edge: assert property (
        irqctl_reg[MPP_IRQ_PIN_EN] && wide_port_one_in[3] &&
            !irq_pin_dly_reg |=> external_irq_req)
        else $error("irq pin edge missed");
    a_wake_key: assert property (
        ram_backup && keyon_reg[0] && key_dly_reg[0] &&
            !wide_port_zero_in[0] |=> wakeup_req)
        else $error("key-on fall missed");
    a_wake_alias: assert property (
        ram_backup && keyon_reg[10] && key_dly_reg[10] &&
            !six_bit_port_in[2] |=> wakeup_req)
        else $error("alias pin key-on fall missed");
    a_read_pin: assert property (
        rd_en && !pready && paddr == MPP_OFS_P0 |=>
            prdata[3:0] == $past(wide_port_zero_in))
        else $error("port read not pin level");
    a_p1_read: assert property (
        rd_en && !pready && paddr == MPP_OFS_P1 |=>
            prdata[3:0] == $past(wide_port_one_in))
        else $error("shared port read not pin level");
    a_skip_read: assert property (
        rd_en && !pready && paddr == MPP_OFS_SKIP && skip_sel_reg == 3'h2
            |=> prdata[0] == $past(six_bit_port_in[2]))
        else $error("skip test level wrong");
    a_reset_pin_rel: assert property (
        !(wdt_reset || por_reset || vdrop_reset) |=> reset_pin_oe_n)
        else $error("reset pin held low without cause");

    c_wake: cover property (ram_backup ##1 wakeup_req);
    c_irq: cover property (external_irq_req ##2 irq);
    c_tmr_out: cover property (func_reg[MPP_FN_TMR_OUT] && tmr_src);
    c_rd: cover property (rd_en ##1 pready);
    c_alias_wake: cover property (keyon_reg[10] && wakeup_req);
endmodule : mpp_pin_port
`default_nettype wire
